// file: dv/tlbinv_props.sv
// Checker: bus handshake and command-register properties of the invalidate block
`timescale 1ns/1ps
`default_nettype none

module tlbinv_props (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Write side
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  // Read side
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  // ****************************************************************
  // Helper: remember each write half so the response can be predicted
  // ****************************************************************
  logic [7:0] aw_addr_r; // Last taken write address
  logic [3:0] w_strb_r; // Last taken write strobes
  wire logic aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire logic w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire logic ar_take = s_axi_arvalid_in && s_axi_arready_out;
  // Only full-word writes to writable places are accepted
  wire logic wr_ok = (w_strb_r == 4'hF) && (aw_addr_r inside {8'h00, 8'h04, 8'h0C, 8'h10});
  wire logic [1:0] exp_bresp = wr_ok ? tlbinv_pkg::TLBINV_RESP_OKAY : tlbinv_pkg::TLBINV_RESP_SLVERR;

  // Capture registers, cleared by reset
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_addr_r <= 8'h00;
      w_strb_r <= 4'h0;
    end else begin
      if (aw_take) aw_addr_r <= s_axi_awaddr_in;
      if (w_take) w_strb_r <= s_axi_wstrb_in;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  AST_WR_LATENCY: assert property (aw_take && w_take |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  AST_WR_RESP: assert property ($rose(s_axi_bvalid_out) |-> s_axi_bresp_out == exp_bresp)
    else $error("write response code wrong");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  AST_B_ONCE: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response repeated");
  AST_ONE_WR: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while response pending");
  AST_RD_LAT: assert property (ar_take |=> s_axi_rvalid_out)
    else $error("read data late");
  AST_RD_CMD_ZERO: assert property (ar_take && s_axi_araddr_in inside {8'h00, 8'h04} |=> s_axi_rdata_out == 32'h0000_0000 && s_axi_rresp_out == 2'h0)
    else $error("command read not zero");
  AST_RD_UNMAPPED: assert property (ar_take && s_axi_araddr_in >= 8'h18 |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) && !s_axi_arready_out)
    else $error("read data dropped early");
endmodule // tlbinv_props

bind tlbinv_top tlbinv_props chk_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_wstrb_in(s_axi_wstrb_in),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_araddr_in(s_axi_araddr_in),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out));

`default_nettype wire

// file: dv/tlbinv_top_tb.sv
// Testbench: register-level scenarios for the translation-cache invalidate block
`timescale 1ns/1ps
`default_nettype none

module tlbinv_top_tb;
  logic sys_clk, resetn, awvalid, wvalid, bready, arvalid, rready; // Bench-driven controls
  logic [7:0] awaddr, araddr; // Addresses
  logic [31:0] wdata; // Write word
  logic [3:0] wstrb; // Write strobes
  wire logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
  wire logic [1:0] bresp, rresp; // Response codes
  wire logic [31:0] rdata; // Read word
  int failures, checks_done; // Counters for the verdict
  logic [31:0] d, s0; // Scratch read values

  tlbinv_top #(.ENTRIES(16)) dut_u (.sys_clk_in(sys_clk), .resetn_in(resetn),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));

  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Verdict, comparison and bus tasks
  // ****************************************************************
  task automatic summarize;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Both halves offered together; bready stays high, so the response is taken at the
  // first edge that samples bvalid high, and bresp is read at that same edge
  task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dw;
    wstrb <= s;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    if (n >= 40) begin
      failures++;
      summarize();
    end
    check({30'h0, bresp}, {30'h0, er});
  endtask

  // Read with rready held high; data taken at the edge that samples rvalid high
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] dr);
    int n;
    n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    dr = rdata;
    if (n >= 40) begin
      failures++;
      summarize();
    end
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // Store one entry; fl is {lock, secure, hyp}
  task automatic fill(input logic [3:0] slot, input logic [19:0] pg, input logic [7:0] tag,
                      input logic [2:0] fl);
    wr(tlbinv_pkg::TLBINV_OFF_FILL_VA, {pg, 8'h00, slot}, 4'hF, 2'h0);
    wr(tlbinv_pkg::TLBINV_OFF_FILL_ATTR, {1'b1, 20'h00000, fl, tag}, 4'hF, 2'h0);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Refusals and command reads leave nothing started
  task automatic sc_regs;
    rd(tlbinv_pkg::TLBINV_OFF_HYP_VA_CMD, 2'h0, d);
    check(d, 32'h0000_0000);
    rd(tlbinv_pkg::TLBINV_OFF_VM_CMD, 2'h0, d);
    check(d, 32'h0000_0000);
    rd(8'h18, 2'h2, d);
    wr(tlbinv_pkg::TLBINV_OFF_HYP_VA_CMD, 32'hFFFF_F000, 4'h7, 2'h2);
    wr(tlbinv_pkg::TLBINV_OFF_VALID, 32'h0000_0000, 4'hF, 2'h2);
    wr(8'h1C, 32'h0000_0000, 4'hF, 2'h2);
    rd(tlbinv_pkg::TLBINV_OFF_STATUS, 2'h0, d);
    check(d, 32'h0000_0000);
  endtask

  // Page command with reserved low bits set
  task automatic sc_hyp;
    fill(4'h0, 20'hABCDE, 8'h05, 3'b001);
    fill(4'h1, 20'hABCDE, 8'h05, 3'b101);
    fill(4'h2, 20'h12345, 8'h05, 3'b001);
    fill(4'h3, 20'hABCDE, 8'h05, 3'b000);
    fill(4'h4, 20'hABCDE, 8'h05, 3'b011);
    rd(tlbinv_pkg::TLBINV_OFF_STATUS, 2'h0, s0);
    wr(tlbinv_pkg::TLBINV_OFF_HYP_VA_CMD, 32'hABCD_EFFF, 4'hF, 2'h0);
    rd(tlbinv_pkg::TLBINV_OFF_VALID, 2'h0, d);
    check({31'h0, d[0]}, 32'h0);
    check({31'h0, d[1]}, 32'h1);
    check(d, 32'h0000_000E);
    rd(tlbinv_pkg::TLBINV_OFF_STATUS, 2'h0, d);
    check({24'h0, d[15:8] - s0[15:8]}, 32'h1);
    rd(tlbinv_pkg::TLBINV_OFF_HYP_VA_CMD, 2'h0, d);
    rd(tlbinv_pkg::TLBINV_OFF_VALID, 2'h0, d);
    check(d, 32'h0000_000E);
  endtask

  // Tag commands back to back, reserved high bits set
  task automatic sc_vm;
    fill(4'h5, 20'h11111, 8'h07, 3'b000);
    fill(4'h6, 20'h11111, 8'h07, 3'b100);
    fill(4'h7, 20'h11111, 8'h07, 3'b010);
    fill(4'h8, 20'h11111, 8'h07, 3'b001);
    fill(4'h9, 20'h11111, 8'h08, 3'b000);
    rd(tlbinv_pkg::TLBINV_OFF_STATUS, 2'h0, s0);
    wr(tlbinv_pkg::TLBINV_OFF_VM_CMD, 32'hFFFF_FF07, 4'hF, 2'h0);
    rd(tlbinv_pkg::TLBINV_OFF_VALID, 2'h0, d);
    check({31'h0, d[5]}, 32'h0);
    check({31'h0, d[6]}, 32'h1);
    check({31'h0, d[7]}, 32'h1);
    check(d, 32'h0000_03CE);
    wr(tlbinv_pkg::TLBINV_OFF_VM_CMD, 32'h0000_0008, 4'hF, 2'h0);
    wr(tlbinv_pkg::TLBINV_OFF_VM_CMD, 32'h0000_0008, 4'hF, 2'h0);
    rd(tlbinv_pkg::TLBINV_OFF_VALID, 2'h0, d);
    check(d, 32'h0000_01CE);
    rd(tlbinv_pkg::TLBINV_OFF_STATUS, 2'h0, d);
    check({24'h0, d[15:8] - s0[15:8]}, 32'h3);
  endtask

  // Main sequence: quiet inputs, reset for three cycles, then scenarios
  initial begin
    failures = 0;
    checks_done = 0;
    resetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    // Response readies held high for the whole run: never toggled between transfers
    {bready, rready} = 2'h3;
    {awaddr, araddr, wstrb, wdata} = 52'h0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    sc_regs();
    sc_hyp();
    sc_vm();
    summarize();
  end
endmodule // tlbinv_top_tb

`default_nettype wire

// file: rtl/tlbinv_entry.sv
// One translation-cache slot with its own match and invalidate logic
`timescale 1ns/1ps
`default_nettype none

module tlbinv_entry #(
  parameter int VA_W = 20,
  parameter int VMT_W = 8
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Fill port
  input wire logic fill_in,
  input wire logic [VA_W-1:0] fill_va_in,
  input wire logic [VMT_W-1:0] fill_vmt_in,
  input wire logic fill_hyp_in,
  input wire logic fill_sec_in,
  input wire logic fill_lock_in,
  // Invalidate request
  input wire logic inv_va_in,
  input wire logic inv_vm_in,
  input wire logic [VA_W-1:0] key_va_in,
  input wire logic [VMT_W-1:0] key_vmt_in,
  // State
  output logic valid_out
);

  // ****************************************************************
  // Entry storage
  // ****************************************************************
  logic valid_r;             // Slot holds a translation
  logic [VA_W-1:0] va_r;     // Page address
  logic [VMT_W-1:0] vmt_r;   // Virtual machine tag
  logic hyp_r;               // Hyp-tagged
  logic sec_r;               // Secure-tagged
  logic lock_r;              // Locked against maintenance

  // ****************************************************************
  // Match terms
  // ****************************************************************
  wire logic va_hit;
  wire logic vm_hit;
  wire logic kill;
  // Exact match on page address of a hyp entry; no over-invalidation,
  // so only precisely targeted unlocked entries ever go away
  // hyp address match
  assign va_hit = hyp_r && (va_r == key_va_in);
  assign vm_hit = !hyp_r && !sec_r && (vmt_r == key_vmt_in);
  assign kill = !lock_r && ((inv_va_in && va_hit) || (inv_vm_in && vm_hit));

  // Store on fill, clear on a matching invalidate; fill wins, it is newer
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_r <= 1'b0;
      va_r <= '0;
      vmt_r <= '0;
      hyp_r <= 1'b0;
      sec_r <= 1'b0;
      lock_r <= 1'b0;
    end else if (fill_in) begin
      valid_r <= 1'b1;
      va_r <= fill_va_in;
      vmt_r <= fill_vmt_in;
      hyp_r <= fill_hyp_in;
      sec_r <= fill_sec_in;
      lock_r <= fill_lock_in;
    end else if (kill) begin
      valid_r <= 1'b0;
    end
  end

  assign valid_out = valid_r;

endmodule // tlbinv_entry
`default_nettype wire

// file: rtl/tlbinv_pkg.sv
// Package: register map, field layout and entry format of the translation-cache invalidate block
package tlbinv_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] TLBINV_OFF_HYP_VA_CMD = 8'h00; // Hyp invalidate by page address
  localparam logic [7:0] TLBINV_OFF_VM_CMD = 8'h04;     // Invalidate by virtual machine tag
  localparam logic [7:0] TLBINV_OFF_STATUS = 8'h08;     // Busy and completion count
  localparam logic [7:0] TLBINV_OFF_FILL_VA = 8'h0C;    // Fill: page address and slot
  localparam logic [7:0] TLBINV_OFF_FILL_ATTR = 8'h10;  // Fill: tag, flags, strobe
  localparam logic [7:0] TLBINV_OFF_VALID = 8'h14;      // Valid bits of the low 32 slots

  // ****************************************************************
  // Command field layout
  // ****************************************************************
  localparam int TLBINV_VA_MSB = 31;   // Page address top bit
  localparam int TLBINV_VA_LSB = 12;   // Page address bottom bit
  localparam int TLBINV_VMT_MSB = 7;   // Virtual machine tag top bit
  localparam int TLBINV_VMT_LSB = 0;   // Virtual machine tag bottom bit
  localparam int TLBINV_VA_W = TLBINV_VA_MSB - TLBINV_VA_LSB + 1;
  localparam int TLBINV_VMT_W = TLBINV_VMT_MSB - TLBINV_VMT_LSB + 1;

  // ****************************************************************
  // Fill attribute word layout
  // ****************************************************************
  localparam int TLBINV_FA_SLOT_LSB = 0;  // Slot index in fill address word
  localparam int TLBINV_FA_SLOT_W = 8;    // Slot index field width
  localparam int TLBINV_AT_HYP = 8;       // Hyp tag flag
  localparam int TLBINV_AT_SEC = 9;       // Secure tag flag
  localparam int TLBINV_AT_LOCK = 10;     // Locked flag
  localparam int TLBINV_AT_GO = 31;       // Write strobe: store the entry

  // ****************************************************************
  // Status layout and reset values
  // ****************************************************************
  localparam int TLBINV_ST_BUSY = 0;      // Sweep in progress
  localparam int TLBINV_ST_CNT_LSB = 8;   // Completed-command count
  localparam int TLBINV_CNT_W = 8;        // Count width
  localparam logic [31:0] TLBINV_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] TLBINV_RESP_OKAY = 2'h0;
  localparam logic [1:0] TLBINV_RESP_SLVERR = 2'h2;

endpackage : tlbinv_pkg

// file: rtl/tlbinv_top.sv
// Translation-cache invalidate-by-address and by-machine-tag block, AXI4-Lite slave
//
// Contract
// - Hyp address command kills matching hyp entries
// - No unlocked matching hyp entry stays valid
// - Extra unlocked kills allowed; locked entries untouched
// - Page address from command bits 31:12
// - Commands are 32-bit write-only words
// - Tag command kills non-secure non-hyp matches
// - Tag command reaches every unlocked match
// - Extra unlocked kills allowed; locked stay valid
// - Tag command never kills secure entries
// - Machine tag from command bits 7:0
`timescale 1ns/1ps
`default_nettype none

module tlbinv_top #(
  parameter int ENTRIES = 16 // Number of translation-cache slots
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out
);

  localparam int VA_W = tlbinv_pkg::TLBINV_VA_W;
  localparam int VMT_W = tlbinv_pkg::TLBINV_VMT_W;
  localparam int SLOT_W = tlbinv_pkg::TLBINV_FA_SLOT_W;
  localparam int CNT_W = tlbinv_pkg::TLBINV_CNT_W;

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic aw_held_r;              // Write address captured
  logic [7:0] aw_addr_r;        // Captured write address
  logic w_held_r;               // Write data captured
  logic [31:0] w_data_r;        // Captured write data
  logic [3:0] w_strb_r;         // Captured byte enables
  logic bvalid_r;               // Write response pending
  logic [1:0] bresp_r;          // Write response code

  wire logic aw_take;
  wire logic w_take;
  wire logic wr_fire;
  // Accept each channel once, independently, while no response is owed
  assign s_axi_awready_out = !aw_held_r && !bvalid_r;
  assign s_axi_wready_out = !w_held_r && !bvalid_r;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  // Write executes in the cycle both halves are present
  assign wr_fire = aw_held_r && w_held_r;

  // Address half holder
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  // Data half holder
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      w_held_r <= 1'b0;
      w_data_r <= tlbinv_pkg::TLBINV_RST_WORD;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata_in;
      w_strb_r <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire logic [7:0] wa;
  wire logic full_word;
  wire logic sel_hva;
  wire logic sel_vm;
  wire logic sel_fva;
  wire logic sel_fat;
  wire logic wr_mapped;
  assign wa = aw_addr_r;
  // Partial writes are refused: a command half-written has no meaning
  assign full_word = (w_strb_r == 4'hF);
  assign sel_hva = (wa == tlbinv_pkg::TLBINV_OFF_HYP_VA_CMD);
  assign sel_vm = (wa == tlbinv_pkg::TLBINV_OFF_VM_CMD);
  assign sel_fva = (wa == tlbinv_pkg::TLBINV_OFF_FILL_VA);
  assign sel_fat = (wa == tlbinv_pkg::TLBINV_OFF_FILL_ATTR);
  assign wr_mapped = full_word && (sel_hva || sel_vm || sel_fva || sel_fat);

  // Response after the write; unmapped or partial gets SLVERR
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bvalid_r <= 1'b0;
      bresp_r <= tlbinv_pkg::TLBINV_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? tlbinv_pkg::TLBINV_RESP_OKAY : tlbinv_pkg::TLBINV_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;

  // ****************************************************************
  // Command issue
  // ****************************************************************
  logic inv_va_r;                 // One-cycle hyp address sweep
  logic inv_vm_r;                 // One-cycle machine tag sweep
  logic [VA_W-1:0] key_va_r;      // Page address key
  logic [VMT_W-1:0] key_vmt_r;    // Machine tag key
  logic [CNT_W-1:0] done_cnt_r;   // Completed commands, wraps
  logic [31:0] fill_va_word_r;    // Staged fill address word

  wire logic cmd_hva;
  wire logic cmd_vm;
  assign cmd_hva = wr_fire && full_word && sel_hva;
  assign cmd_vm = wr_fire && full_word && sel_vm;

  // Every slot compares in parallel, so a sweep takes a single cycle and
  // the next command can never overtake it; area traded for latency
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      inv_va_r <= 1'b0;
      inv_vm_r <= 1'b0;
      key_va_r <= '0;
      key_vmt_r <= '0;
    end else begin
      inv_va_r <= cmd_hva;
      inv_vm_r <= cmd_vm;
      if (cmd_hva) begin
        key_va_r <= w_data_r[tlbinv_pkg::TLBINV_VA_MSB:tlbinv_pkg::TLBINV_VA_LSB];
      end
      if (cmd_vm) begin
        key_vmt_r <= w_data_r[tlbinv_pkg::TLBINV_VMT_MSB:tlbinv_pkg::TLBINV_VMT_LSB];
      end
    end
  end

  // Completion counter, bumped as each sweep lands
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_cnt_r <= '0;
    end else if (inv_va_r || inv_vm_r) begin
      done_cnt_r <= done_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // Fill path (software-loaded entries for this block)
  // ****************************************************************
  wire logic fill_go;
  wire logic [SLOT_W-1:0] fill_slot;
  assign fill_go = wr_fire && full_word && sel_fat && w_data_r[tlbinv_pkg::TLBINV_AT_GO];
  assign fill_slot = fill_va_word_r[tlbinv_pkg::TLBINV_FA_SLOT_LSB +: SLOT_W];

  // Stage the address word until the attribute strobe arrives
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fill_va_word_r <= tlbinv_pkg::TLBINV_RST_WORD;
    end else if (wr_fire && full_word && sel_fva) begin
      fill_va_word_r <= w_data_r;
    end
  end

  // ****************************************************************
  // Entry array
  // ****************************************************************
  wire logic [ENTRIES-1:0] valid_vec;
  for (genvar g = 0; g < ENTRIES; g++) begin : g_slot
    wire logic fill_me;
    // Out-of-range slot numbers simply store nowhere
    assign fill_me = fill_go && (fill_slot == SLOT_W'(g));
    tlbinv_entry #(
      .VA_W(VA_W),
      .VMT_W(VMT_W)
    ) u_entry (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .fill_in(fill_me),
      .fill_va_in(fill_va_word_r[tlbinv_pkg::TLBINV_VA_MSB:tlbinv_pkg::TLBINV_VA_LSB]),
      .fill_vmt_in(w_data_r[tlbinv_pkg::TLBINV_VMT_MSB:tlbinv_pkg::TLBINV_VMT_LSB]),
      .fill_hyp_in(w_data_r[tlbinv_pkg::TLBINV_AT_HYP]),
      .fill_sec_in(w_data_r[tlbinv_pkg::TLBINV_AT_SEC]),
      .fill_lock_in(w_data_r[tlbinv_pkg::TLBINV_AT_LOCK]),
      .inv_va_in(inv_va_r),
      .inv_vm_in(inv_vm_r),
      .key_va_in(key_va_r),
      .key_vmt_in(key_vmt_r),
      .valid_out(valid_vec[g])
    );
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic rvalid_r;          // Read data pending
  logic [31:0] rdata_r;    // Read data
  logic [1:0] rresp_r;     // Read response code

  wire logic ar_take;
  wire logic [7:0] ra;
  wire logic rd_status;
  wire logic rd_valid;
  wire logic rd_fva;
  wire logic rd_cmd;
  wire logic rd_known;
  wire logic [31:0] status_word;
  wire logic [31:0] valid_word;
  wire logic [31:0] rd_word;
  assign s_axi_arready_out = !rvalid_r;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign ra = s_axi_araddr_in;
  assign rd_status = (ra == tlbinv_pkg::TLBINV_OFF_STATUS);
  assign rd_valid = (ra == tlbinv_pkg::TLBINV_OFF_VALID);
  assign rd_fva = (ra == tlbinv_pkg::TLBINV_OFF_FILL_VA);
  assign rd_cmd = (ra == tlbinv_pkg::TLBINV_OFF_HYP_VA_CMD) ||
                  (ra == tlbinv_pkg::TLBINV_OFF_VM_CMD) ||
                  (ra == tlbinv_pkg::TLBINV_OFF_FILL_ATTR);
  assign rd_known = rd_status || rd_valid || rd_fva || rd_cmd;
  assign status_word = {16'h0000, done_cnt_r, 7'h00, inv_va_r || inv_vm_r};
  // Only the low 32 slots are visible; larger arrays read truncated
  assign valid_word = 32'(valid_vec);
  assign rd_word = rd_status ? status_word :
                   rd_valid ? valid_word :
                   rd_fva ? fill_va_word_r : tlbinv_pkg::TLBINV_RST_WORD;

  // Read answer one cycle after the address is taken
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= tlbinv_pkg::TLBINV_RST_WORD;
      rresp_r <= tlbinv_pkg::TLBINV_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_known ? tlbinv_pkg::TLBINV_RESP_OKAY : tlbinv_pkg::TLBINV_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;

endmodule // tlbinv_top
`default_nettype wire
